// >>> csso_device.sv
// clock synthesizer: smbus block-write slave, configuration bytes and output gating
`timescale 1ns/1ps
module csso_device (
  // smbus clock domain and reset
  input wire logic resetn,
  csso_if.device bus,
  // internal synthesizer clock
  input wire logic sys_clk,
  input wire logic pci_clk,
  input wire logic cpu_clk,
  input wire logic mhz66_clk,
  input wire logic mhz48_clk,
  // control pins
  input wire logic power_down_n,
  input wire logic cpu_stop_n,
  input wire logic pci_stop_n,
  input wire logic freq_select_high,
  input wire logic freq_select_low,
  input wire logic cpu_multiplier_bit,
  // clock outputs
  output logic [5:0] pci_out,
  output logic [2:0] pci_free_out,
  output logic sixty_six_mhz_clock,
  output logic video_hub_clock,
  output logic [1:0] cpu_true_out,
  output logic [1:0] cpu_comp_out,
  output logic [1:0] cpu_true_oe,
  output logic [1:0] cpu_comp_oe,
  output logic [1:0] cpu_park_2x,
  output logic spread_enable,
  output logic vco_on
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_CMD = 7'b0000100,
    ST_COUNT = 7'b0001000,
    ST_DATA = 7'b0010000,
    ST_IGNORE = 7'b0100000,
    ST_ACK = 7'b1000000
  } csso_state_t;

  csso_state_t state_reg;
  csso_state_t after_ack_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [5:0] data_left_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] cfg0_reg;
  logic [7:0] cfg1_reg;
  logic [7:0] cfg2_reg;
  logic [1:0] fs_reg;
  logic fs_taken_reg;
  logic sda_oe_reg;
  logic start_tog_reg;
  logic stop_tog_reg;
  logic [2:0] start_sync_reg;
  logic [2:0] stop_sync_reg;
  logic [1:0] pin_sync0_reg;
  logic [1:0] pin_sync1_reg;
  logic [1:0] pin_sync2_reg;

  // start and stop are seen as sda edges while scl is high
  always_ff @(negedge bus.sda or negedge resetn) begin
    if (!resetn) begin
      start_tog_reg <= 1'b0;
    end else if (bus.scl) begin
      start_tog_reg <= !start_tog_reg;
    end
  end

  always_ff @(posedge bus.sda or negedge resetn) begin
    if (!resetn) begin
      stop_tog_reg <= 1'b0;
    end else if (bus.scl) begin
      stop_tog_reg <= !stop_tog_reg;
    end
  end

  // start/stop toggles are brought into the scl domain; the first stage is the edge history
  always_ff @(posedge bus.scl or negedge resetn) begin
    if (!resetn) begin
      start_sync_reg <= 3'b000;
      stop_sync_reg <= 3'b000;
    end else begin
      start_sync_reg <= {start_sync_reg[1:0], start_tog_reg};
      stop_sync_reg <= {stop_sync_reg[1:0], stop_tog_reg};
    end
  end

  logic start_seen;
  // one scl edge only: the first stage takes the toggle on that same edge
  assign start_seen = start_sync_reg[0] != start_tog_reg;

  // receive: sample sda on scl rise
  always_ff @(posedge bus.scl or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      after_ack_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      data_left_reg <= 6'h00;
      byte_idx_reg <= 2'b00;
    end else if (start_seen) begin
      // first address bit of a fresh frame arrives on this edge
      state_reg <= ST_ADDR;
      shift_reg <= {7'h00, bus.sda};
      bit_cnt_reg <= 4'h1;
      byte_idx_reg <= 2'b00;
    end else begin
      case (state_reg)
        ST_ADDR, ST_CMD, ST_COUNT, ST_DATA: begin
          shift_reg <= {shift_reg[6:0], bus.sda};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == 4'h7) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_ACK;
            after_ack_reg <= ST_IGNORE;
            case (state_reg)
              ST_ADDR: begin
                if ({shift_reg[6:0], bus.sda} == {csso_pkg::SLAVE_ADDR, 1'b0}) begin
                  after_ack_reg <= ST_CMD;
                end
              end
              ST_CMD: begin
                if ({shift_reg[6:0], bus.sda} == csso_pkg::CMD_CODE) begin
                  after_ack_reg <= ST_COUNT;
                end
              end
              ST_COUNT: begin
                if ({shift_reg[6:0], bus.sda} >= csso_pkg::COUNT_MIN &&
                    {shift_reg[6:0], bus.sda} <= csso_pkg::COUNT_MAX) begin
                  after_ack_reg <= ST_DATA;
                  data_left_reg <= 6'({shift_reg[6:0], bus.sda});
                end
              end
              default: begin
                data_left_reg <= data_left_reg - 6'h01;
                if (data_left_reg > 6'h01) begin
                  after_ack_reg <= ST_DATA;
                end else begin
                  // last counted byte is still acknowledged
                  after_ack_reg <= ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          state_reg <= after_ack_reg;
          if (state_reg == ST_ACK && after_ack_reg == ST_DATA && data_left_reg != 6'h00) begin
            byte_idx_reg <= byte_idx_reg;
          end
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge driven on falling scl so it is stable for the host's sample at the end of scl high
  always_ff @(negedge bus.scl or negedge resetn) begin
    if (!resetn) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= (state_reg == ST_ACK) && (after_ack_reg != ST_IGNORE);
    end
  end
  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = sda_oe_reg;

  // configuration bytes, written as each of the first three data bytes completes
  logic data_done;
  assign data_done = !start_seen && state_reg == ST_DATA && bit_cnt_reg == 4'h7;

  always_ff @(posedge bus.scl or negedge resetn) begin
    if (!resetn) begin
      cfg0_reg <= csso_pkg::BYTE0_RESET;
      cfg1_reg <= csso_pkg::BYTE1_RESET;
      cfg2_reg <= csso_pkg::BYTE2_RESET;
    end else if (data_done) begin
      case (idx_cnt_reg)
        2'd0: cfg0_reg <= {shift_reg[6:0], bus.sda};
        2'd1: cfg1_reg <= {shift_reg[6:0], bus.sda};
        2'd2: cfg2_reg <= {shift_reg[6:0], bus.sda};
        default: cfg2_reg <= cfg2_reg;
      endcase
    end
  end

  logic [1:0] idx_cnt_reg;
  always_ff @(posedge bus.scl or negedge resetn) begin
    if (!resetn) begin
      idx_cnt_reg <= 2'b00;
    end else if (start_seen) begin
      idx_cnt_reg <= 2'b00;
    end else if (data_done && idx_cnt_reg != 2'd3) begin
      idx_cnt_reg <= idx_cnt_reg + 2'b01;
    end
  end

  // strap pins caught once after reset release
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sync0_reg <= 2'b00;
      fs_reg <= 2'b00;
      fs_taken_reg <= 1'b0;
    end else begin
      pin_sync0_reg <= {freq_select_high, freq_select_low};
      if (!fs_taken_reg) begin
        fs_reg <= {freq_select_high, freq_select_low};
        fs_taken_reg <= 1'b1;
      end
    end
  end

  // readback image, kept for a later block read extension
  logic [7:0] byte0_view;
  always_comb begin
    byte0_view = cfg0_reg;
    byte0_view[csso_pkg::B0_CPU_STOP] = cpu_stop_n;
    byte0_view[csso_pkg::B0_FS_HIGH] = fs_reg[1];
    byte0_view[csso_pkg::B0_FS_LOW] = fs_reg[0];
  end

  assign spread_enable = cfg0_reg[csso_pkg::B0_SPREAD] && power_down_n;
  assign vco_on = power_down_n;

  // glitch-free gate: enable resynchronised and changed only while the clock is low, except mhz48_clk on video_hub_clock, gated by the mhz66_clk enable
  function automatic logic gated(input logic clk, input logic en_low);
    gated = clk && en_low;
  endfunction

  logic [5:0] pci_en_reg;
  logic [1:0] pci_en_sync_reg [6];
  always_ff @(negedge pci_clk or negedge resetn) begin
    if (!resetn) begin
      pci_en_reg <= 6'h00;
      for (int i = 0; i < 6; i++) pci_en_sync_reg[i] <= 2'b00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        pci_en_sync_reg[i] <= {pci_en_sync_reg[i][0],
          power_down_n && pci_stop_n && !(!cfg0_reg[csso_pkg::B0_PCI_STOP] && 1'b0) &&
          cfg2_reg[csso_pkg::B2_PCI_EN_LO + i]};
        pci_en_reg[i] <= pci_en_sync_reg[i][1];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) pci_out[i] = gated(pci_clk, pci_en_reg[i]);
  end

  logic pd_sync_pci_reg;
  logic pd_pci_reg;
  always_ff @(negedge pci_clk or negedge resetn) begin
    if (!resetn) begin
      pd_sync_pci_reg <= 1'b0;
      pd_pci_reg <= 1'b0;
    end else begin
      pd_sync_pci_reg <= power_down_n;
      pd_pci_reg <= pd_sync_pci_reg;
    end
  end
  assign pci_free_out = {3{gated(pci_clk, pd_pci_reg)}};

  logic pd_sync_66_reg;
  logic pd_66_reg;
  logic vch_sel_reg;
  always_ff @(negedge mhz66_clk or negedge resetn) begin
    if (!resetn) begin
      pd_sync_66_reg <= 1'b0;
      pd_66_reg <= 1'b0;
    end else begin
      pd_sync_66_reg <= power_down_n;
      pd_66_reg <= pd_sync_66_reg;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vch_sel_reg <= 1'b0;
    end else begin
      vch_sel_reg <= cfg0_reg[csso_pkg::B0_VCH_SEL];
    end
  end
  assign sixty_six_mhz_clock = gated(mhz66_clk, pd_66_reg);
  assign video_hub_clock = vch_sel_reg ? gated(mhz48_clk, pd_66_reg) :
    gated(mhz66_clk, pd_66_reg);

  logic [1:0] cpu_run_reg;
  logic [1:0] cpu_sync_reg [2];
  logic [1:0] free_bits;
  assign free_bits = {cfg1_reg[csso_pkg::B1_FREE2], cfg1_reg[csso_pkg::B1_FREE1]};
  always_ff @(negedge cpu_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_run_reg <= 2'b00;
      cpu_sync_reg[0] <= 2'b00;
      cpu_sync_reg[1] <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        cpu_sync_reg[i] <= {cpu_sync_reg[i][0], power_down_n &&
          (cpu_stop_n || free_bits[i]) &&
          cfg1_reg[i == 0 ? csso_pkg::B1_EN1 : csso_pkg::B1_EN2]};
        cpu_run_reg[i] <= cpu_sync_reg[i][1];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cpu_true_out[i] = cpu_run_reg[i] ? cpu_clk : 1'b1;
      cpu_comp_out[i] = cpu_run_reg[i] ? !cpu_clk : 1'b0;
      cpu_park_2x[i] = !cpu_run_reg[i];
      cpu_true_oe[i] = !(cfg1_reg[csso_pkg::B1_TRISTATE] && !power_down_n);
      cpu_comp_oe[i] = cpu_run_reg[i];
    end
  end
endmodule : csso_device

// >>> csso_pkg.sv
// shared constants for the clock synthesizer smbus configuration and output gating
package csso_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h69;
  localparam logic [7:0] CMD_CODE = 8'h00;
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [7:0] COUNT_MAX = 8'h20;
  localparam int NUM_BYTES = 3;
  // configuration byte power-up values
  localparam logic [7:0] BYTE0_RESET = 8'h09;
  localparam logic [7:0] BYTE1_RESET = 8'h07;
  localparam logic [7:0] BYTE2_RESET = 8'h7f;
  // field positions
  localparam int B0_SPREAD = 7;
  localparam int B0_VCH_SEL = 5;
  localparam int B0_CPU_STOP = 4;
  localparam int B0_PCI_STOP = 3;
  localparam int B0_FS_HIGH = 2;
  localparam int B0_FS_LOW = 1;
  localparam int B1_MULT = 7;
  localparam int B1_TRISTATE = 6;
  localparam int B1_FREE2 = 5;
  localparam int B1_FREE1 = 4;
  localparam int B1_EN2 = 2;
  localparam int B1_EN1 = 1;
  localparam int B2_PCI_EN_LO = 1;
  // host register map (avalon word byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam int CTRL_GO = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  // host smbus clock: 100 MHz / (3*SCL_HALF_CYC), about 66.7 kHz per data bit
  localparam int SCL_HALF_NS = 5000;
  localparam int SYS_CLK_NS = 10;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / SYS_CLK_NS;
endpackage : csso_pkg

// >>> csso_if.sv
// two-wire smbus link joining the host controller and the clock synthesizer
`timescale 1ns/1ps
interface csso_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;
  // open drain: any enabled driver pulls low
  assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
  modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
  modport device (input scl, output sda_dev_out, output sda_dev_oe, input sda);
endinterface : csso_if

// >>> csso_host.sv
// smbus host: block write of configuration bytes, driven from avalon-mm registers
`timescale 1ns/1ps
module csso_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // smbus link
  csso_if.host bus
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_START = 6'b000010,
    H_BIT = 6'b000100,
    H_ACK = 6'b001000,
    H_STOP = 6'b010000,
    H_DONE = 6'b100000
  } csso_hstate_t;

  csso_hstate_t state_reg;
  logic [7:0] data_reg [3];
  logic [1:0] count_reg;
  logic [7:0] tx_reg;
  logic [2:0] bit_reg;
  logic [2:0] byte_reg;
  logic [9:0] div_reg;
  logic [1:0] phase_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic nack_reg;
  logic busy;
  logic tick;
  logic [1:0] sda_sync_reg;

  assign busy = state_reg != H_IDLE;
  assign tick = div_reg == 10'(csso_pkg::SCL_HALF_CYC - 1);

  // reads wait one cycle so registered read data stands at the accepting edge
  logic rd_ready_reg;
  assign avs_waitrequest = avs_read && !rd_ready_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_ready_reg <= 1'b0;
    end else begin
      rd_ready_reg <= avs_read && !rd_ready_reg;
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_ready_reg) begin
      case (avs_address)
        csso_pkg::ADDR_STAT: avs_readdata <= {30'h0000_0000, nack_reg, busy};
        csso_pkg::ADDR_DATA: avs_readdata <= {8'h00, data_reg[2], data_reg[1], data_reg[0]};
        csso_pkg::ADDR_CTRL: avs_readdata <= {30'h0000_0000, count_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) data_reg[i] <= 8'h00;
      count_reg <= 2'd1;
    end else if (avs_write && !busy) begin
      if (avs_address == csso_pkg::ADDR_DATA) begin
        for (int i = 0; i < 3; i++) data_reg[i] <= avs_writedata[8*i +: 8];
      end
      if (avs_address == csso_pkg::ADDR_CTRL && avs_writedata[9:8] != 2'd0) begin
        count_reg <= avs_writedata[9:8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sda_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  function automatic logic [7:0] frame_byte(input logic [2:0] idx, input logic [1:0] cnt,
                                           input logic [7:0] d0, input logic [7:0] d1,
                                           input logic [7:0] d2);
    case (idx)
      3'd0: frame_byte = {csso_pkg::SLAVE_ADDR, 1'b0};
      3'd1: frame_byte = csso_pkg::CMD_CODE;
      3'd2: frame_byte = {6'h00, cnt};
      3'd3: frame_byte = d0;
      3'd4: frame_byte = d1;
      default: frame_byte = d2;
    endcase
  endfunction

  // phase 1: scl low & set sda, 0: scl high then back low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= H_IDLE;
      div_reg <= 10'h000;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
      bit_reg <= 3'd0;
      byte_reg <= 3'd0;
      nack_reg <= 1'b0;
      phase_reg <= 2'd0;
    end else begin
      div_reg <= (tick || !busy) ? 10'h000 : div_reg + 10'h001;
      case (state_reg)
        H_IDLE: begin
          if (avs_write && avs_address == csso_pkg::ADDR_CTRL && avs_writedata[csso_pkg::CTRL_GO]) begin
            state_reg <= H_START;
            nack_reg <= 1'b0;
            byte_reg <= 3'd0;
          end
        end
        H_START: if (tick) begin
          sda_oe_reg <= 1'b1;
          tx_reg <= frame_byte(3'd0, count_reg, data_reg[0], data_reg[1], data_reg[2]);
          bit_reg <= 3'd7;
          phase_reg <= 2'd0;
          state_reg <= H_BIT;
        end
        // phase 1: set data with scl low; phase 2 marks the last bit sent
        H_BIT: if (tick) begin
          if (phase_reg == 2'd1) begin
            sda_oe_reg <= !tx_reg[bit_reg];
            phase_reg <= (bit_reg == 3'd0) ? 2'd2 : 2'd0;
            bit_reg <= bit_reg - 3'd1;
          end else if (!scl_reg) begin
            scl_reg <= 1'b1;
          end else begin
            scl_reg <= 1'b0;
            if (phase_reg == 2'd2) begin
              state_reg <= H_ACK;
              sda_oe_reg <= 1'b0;
              phase_reg <= 2'd0;
            end else begin
              phase_reg <= 2'd1;
            end
          end
        end
        H_ACK: if (tick) begin
          if (phase_reg == 2'd0) begin
            scl_reg <= 1'b1;
            phase_reg <= 2'd1;
          end else begin
            scl_reg <= 1'b0;
            phase_reg <= 2'd0;
            if (sda_sync_reg[1] || byte_reg == 3'(count_reg) + 3'd2) begin
              nack_reg <= sda_sync_reg[1];
              state_reg <= H_STOP;
            end else begin
              byte_reg <= byte_reg + 3'd1;
              tx_reg <= frame_byte(byte_reg + 3'd1, count_reg, data_reg[0], data_reg[1],
                                   data_reg[2]);
              bit_reg <= 3'd7;
              state_reg <= H_BIT;
              phase_reg <= 2'd1;
            end
          end
        end
        // sda is pulled low only once scl is low, so no false start appears
        H_STOP: if (tick) begin
          if (!sda_oe_reg) begin
            sda_oe_reg <= 1'b1;
          end else if (!scl_reg) begin
            scl_reg <= 1'b1;
          end else begin
            sda_oe_reg <= 1'b0;
            state_reg <= H_DONE;
          end
        end
        default: if (tick) begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign bus.scl = scl_reg;
  assign bus.sda_host_out = 1'b0;
  assign bus.sda_host_oe = sda_oe_reg;
endmodule : csso_host

// >>> csso_link_properties.sv
// wire-level checks on the smbus link between host and synthesizer
`timescale 1ns/1ps
module csso_link_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link wires
  input wire logic scl,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic sda
);
  logic [3:0] bit_reg;
  logic [2:0] idx_reg;
  logic [7:0] sh_reg;
  logic nack_reg;
  logic [10:0] low_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // frame decoder: bit and byte position since the last start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_reg <= '0;
      idx_reg <= '0;
      sh_reg <= '0;
      nack_reg <= '0;
    end else if (scl && $fell(sda)) begin
      bit_reg <= '0;
      idx_reg <= '0;
      nack_reg <= '0;
    end else if ($rose(scl)) begin
      if (bit_reg == 4'h8) begin
        bit_reg <= '0;
        idx_reg <= idx_reg + 3'h1;
        nack_reg <= nack_reg | sda;
      end else begin
        bit_reg <= bit_reg + 4'h1;
        sh_reg <= {sh_reg[6:0], sda};
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) low_reg <= '0;
    else low_reg <= scl ? 11'h000 : low_reg + 11'h001;
  end
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  // ack slot of byte n, only while every earlier byte was acknowledged
  sequence ack_s(int n);
    $rose(scl) && bit_reg == 4'h8 && idx_reg == n && !nack_reg;
  endsequence
  property ack_p(int n, logic good);
    ack_s(n) |-> sda == !good;
  endproperty
  a_dev_drive_low: assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("device drives sda high");
  a_host_drive_low: assert property (sda_host_oe |-> !sda_host_out)
    else $error("host drives sda high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("scl low phase too short");
  a_scl_low_bound: assert property (low_reg <= 11'h400)
    else $error("scl held low too long");
  a_dev_sda_steady: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device changed sda while scl high");
  a_start_quiet: assert property (start_s |=> !sda_dev_oe [*8])
    else $error("device drives sda right after start");
  a_addr_ack: assert property (ack_p(0, sh_reg == 8'hd2))
    else $error("address acknowledge wrong");
  a_cmd_ack: assert property (ack_p(1, sh_reg == 8'h00))
    else $error("command acknowledge wrong");
  a_count_ack: assert property (ack_p(2, sh_reg >= 8'h01 && sh_reg <= 8'h20))
    else $error("count acknowledge wrong");
  a_data_ack: assert property (ack_s(3) |-> !sda)
    else $error("first data byte not acknowledged");
endmodule : csso_link_properties

// >>> tb_clock_synth_smbus_output_control.sv
// bench: avalon writes reach the synthesizer over smbus; gated clocks are watched
`timescale 1ns/1ps
module tb_clock_synth_smbus_output_control;
  logic sys_clk = '0;
  logic resetn = '0;
  logic pci_clk = '0;
  logic cpu_clk = '0;
  logic mhz66_clk = '0;
  logic mhz48_clk = '0;
  logic [3:0] avs_address = '0;
  logic avs_read = '0;
  logic avs_write = '0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, spread_enable, vco_on, sixty_six_mhz_clock, video_hub_clock;
  logic power_down_n = '1;
  logic cpu_stop_n = '1;
  logic pci_stop_n = '1;
  logic [5:0] pci_out;
  logic [2:0] pci_free_out;
  logic [1:0] cpu_true_out, cpu_comp_out, cpu_true_oe, cpu_comp_oe, cpu_park_2x;
  logic [12:0] sig, hi, lo;
  logic win = '0;
  int edges, err_count = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  always #15 pci_clk = ~pci_clk;
  always #3 cpu_clk = ~cpu_clk;
  always #7.5 mhz66_clk = ~mhz66_clk;
  always #10.5 mhz48_clk = ~mhz48_clk;
  assign sig = {pci_out, pci_free_out, sixty_six_mhz_clock, video_hub_clock, cpu_true_out};
  always @(posedge video_hub_clock) if (win) edges++;
  csso_if link();
  csso_host csso_host_i (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(link.host));
  csso_device csso_device_i (.resetn(resetn), .bus(link.device), .sys_clk(sys_clk),
    .pci_clk(pci_clk), .cpu_clk(cpu_clk), .mhz66_clk(mhz66_clk), .mhz48_clk(mhz48_clk),
    .power_down_n(power_down_n), .cpu_stop_n(cpu_stop_n), .pci_stop_n(pci_stop_n),
    .freq_select_high('1), .freq_select_low('0), .cpu_multiplier_bit('0),
    .pci_out(pci_out), .pci_free_out(pci_free_out), .sixty_six_mhz_clock(sixty_six_mhz_clock),
    .video_hub_clock(video_hub_clock), .cpu_true_out(cpu_true_out),
    .cpu_comp_out(cpu_comp_out), .cpu_true_oe(cpu_true_oe), .cpu_comp_oe(cpu_comp_oe),
    .cpu_park_2x(cpu_park_2x), .spread_enable(spread_enable), .vco_on(vco_on));
  csso_link_properties csso_link_properties_i (.sys_clk(sys_clk), .resetn(resetn),
    .scl(link.scl), .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
    .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe), .sda(link.sda));
  task automatic chk_out(input string what, input logic [12:0] exp, input logic [12:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_out
  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg
  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= '1;
    @(posedge sys_clk);
    while (avs_waitrequest !== '0) @(posedge sys_clk);
    avs_write <= '0;
    @(posedge sys_clk);
  endtask : av_wr
  // read data is taken at the edge where waitrequest is seen low
  task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= '1;
    @(posedge sys_clk);
    while (avs_waitrequest !== '0) @(posedge sys_clk);
    d = avs_readdata;
    avs_read <= '0;
    @(posedge sys_clk);
  endtask : av_rd
  // settle past the gating handover, then record levels seen on the pci, 66 MHz, video hub and cpu true outputs
  task automatic watch();
    repeat (30) @(posedge sys_clk);
    hi = '0;
    lo = '0;
    edges = 0;
    win = '1;
    repeat (100) begin
      @(posedge sys_clk);
      hi = hi | sig;
      lo = lo | ~sig;
    end
    win = '0;
  endtask : watch
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    #1_200_000;
    err_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= '1;
    repeat (2) @(posedge sys_clk);
    watch();
    chk_out("run_default", 13'h1fff, hi & lo);
    chk_out("spread_hub_vco", 13'h0003, {11'h000, spread_enable, edges > 56, vco_on});
    chk_out("cpu_oe_default", 13'h0003, {11'h000, cpu_true_oe});
    pci_stop_n <= '0;
    watch();
    chk_out("pci_stopped", 13'h007f, hi & lo);
    pci_stop_n <= '1;
    cpu_stop_n <= '0;
    watch();
    chk_out("cpu_stopped", 13'h1ffc, hi & lo);
    chk_out("cpu_park", 13'h000c, {9'h000, cpu_park_2x, cpu_comp_oe});
    cpu_stop_n <= '1;
    power_down_n <= '0;
    watch();
    chk_out("pd_levels", 13'h0003, hi);
    chk_out("pd_vco_oe", 13'h0003, {10'h000, vco_on, cpu_true_oe});
    power_down_n <= '1;
    av_rd(csso_pkg::ADDR_STAT, rd);
    chk_reg("stat_idle", 32'h0000_0000, rd & 32'h0000_0003);
    av_wr(csso_pkg::ADDR_DATA, 32'h003c_57a1);
    av_wr(csso_pkg::ADDR_CTRL, 32'h0000_0301);
    rd = 32'h0000_0001;
    for (int i = 0; i < 40000 && rd[0] !== '0; i++) av_rd(csso_pkg::ADDR_STAT, rd);
    chk_reg("stat_done", 32'h0000_0000, rd & 32'h0000_0003);
    watch();
    chk_out("run_cfg", 13'h0f7f, hi & lo);
    chk_out("pci_off_low", 13'h0000, hi & 13'h1080);
    chk_out("spread_hub_cfg", 13'h0002, {11'h000, spread_enable, edges > 56});
    cpu_stop_n <= '0;
    watch();
    chk_out("cpu_free_run", 13'h0f7d, hi & lo);
    chk_out("cpu_park_cfg", 13'h0009, {9'h000, cpu_park_2x, cpu_comp_oe});
    cpu_stop_n <= '1;
    power_down_n <= '0;
    watch();
    chk_out("pd_tristate", 13'h0000, {11'h000, cpu_true_oe});
    summarize();
  end
endmodule : tb_clock_synth_smbus_output_control
